// >>> core/exec_unit.sv
// Execution unit for subtract, xor, nibble exchange and sleep, with
// working register, flags, register file and watchdog, on Avalon-MM.
// Assumes a single 50 MHz core clock and an Avalon master that holds
// each request until waitrequest is seen low.
`timescale 1ns/1ns
`default_nettype none
module exec_unit
   import exec_pkg::*;
#(
   parameter int TICK_DIV = WDOG_TICK_DIV // Watchdog step divider
)
(
   input wire logic mclk_i, // Core clock
   input wire logic rstn_i, // Synchronous reset, active low
   input wire logic [ADDR_W-1:0] address_i, // Byte address
   input wire logic read_i, // Read request
   input wire logic write_i, // Write request
   input wire logic [3:0] byteenable_i, // Byte lanes
   input wire logic [31:0] writedata_i, // Write data
   output logic [31:0] readdata_o, // Read data, registered
   output logic waitrequest_o, // Stall until the answer cycle
   output logic halted_o // Core is in the sleep state
);
   // ---------------------------------------------------------------
   // Types and helpers
   // ---------------------------------------------------------------
   typedef enum logic {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} bus_st_t;
   typedef enum logic {CORE_RUN = 1'b0, CORE_HALT = 1'b1} core_st_t;

   // Register file window hit, used by read and write decode
   function automatic logic rf_hit(input logic [ADDR_W-1:0] a);
      rf_hit = (a[ADDR_W-1:8] == OFS_RF_BASE[ADDR_W-1:8]);
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   bus_st_t bus_q, bus_d; // Bus handshake phase
   core_st_t core_q, core_d; // Run or halted
   logic [31:0] rdata_q, rdata_d; // Read data holding register
   logic [7:0] work_q, work_d; // Working register
   logic carry_q, carry_d; // Carry flag
   logic half_q, half_d; // Half carry flag
   logic zero_q, zero_d; // Zero flag
   logic pd_n_q, pd_n_d; // powerdown_flag_n
   logic to_n_q, to_n_d; // watchdog_expiry_flag_n
   logic [7:0] rf_q [REG_NUM]; // Register file
   logic [7:0] rf_d [REG_NUM];

   // ---------------------------------------------------------------
   // Instruction decode from the bus word
   // ---------------------------------------------------------------
   logic req; // A request is present
   logic take; // Request completes this cycle
   logic wr_take; // Write takes effect at the coming edge
   logic exec; // Instruction issues at the coming edge
   op_t op; // Opcode field
   logic dest; // Destination bit
   logic [REG_AW-1:0] raddr; // Register address field
   logic [7:0] imm; // Immediate field
   logic [7:0] rval; // Addressed register value
   logic reg_op; // Opcode with a register destination choice
   logic [REG_AW-1:0] bus_idx; // Register window index

   always_comb
   begin
      req = read_i | write_i;
      take = req && (bus_q == BUS_ACK);
      wr_take = take && write_i;
      op = op_t'(writedata_i[INS_OP_LSB +: 3]);
      dest = writedata_i[INS_DEST_BIT];
      raddr = writedata_i[INS_REG_LSB +: REG_AW];
      imm = writedata_i[INS_IMM_LSB +: 8];
      rval = rf_q[raddr];
      bus_idx = address_i[REG_AW+1:2];
      // A halted core ignores issued instructions
      exec = wr_take && (address_i == OFS_INSTR) && byteenable_i[0]
         && (core_q == CORE_RUN);
      reg_op = (op == OP_SBC) || (op == OP_SUBR) || (op == OP_SWAP)
         || (op == OP_XORR);
   end

   // ---------------------------------------------------------------
   // Datapath units
   // ---------------------------------------------------------------
   logic [7:0] alu_res; // Result byte
   logic alu_c; // Carry out
   logic alu_h; // Half carry out
   logic alu_z; // Zero result
   logic alu_upd_c; // Carry and half carry update
   logic alu_upd_z; // Zero update
   logic [7:0] wd_count; // Watchdog counter
   logic [7:0] wd_presc; // Watchdog prescaler
   logic sleep_exec; // Sleep issues now

   assign sleep_exec = exec && (op == OP_SLEEP);

   exec_alu u_alu (
      .op_i(op),
      .reg_i(rval),
      .work_i(work_q),
      .imm_i(imm),
      .carry_i(carry_q),
      .res_o(alu_res),
      .carry_o(alu_c),
      .half_o(alu_h),
      .zero_o(alu_z),
      .upd_c_o(alu_upd_c),
      .upd_z_o(alu_upd_z)
   );

   exec_wdog #(
      .TICK_DIV(TICK_DIV)
   ) u_wdog (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .clear_i(sleep_exec),
      .count_o(wd_count),
      .presc_o(wd_presc)
   );

   // ---------------------------------------------------------------
   // Bus handshake and read mux
   // ---------------------------------------------------------------
   // One wait cycle gives the read mux a full cycle and keeps
   // readdata registered
   always_comb
   begin
      bus_d = bus_q;
      rdata_d = rdata_q;
      case (bus_q)
         BUS_IDLE:
         begin
            if (req)
            begin
               bus_d = BUS_ACK;
               rdata_d = 32'h0000_0000; // Unmapped reads give zero
               if (rf_hit(address_i))
               begin
                  rdata_d = {24'h00_0000, rf_q[bus_idx]};
               end
               else if (address_i == OFS_WORK)
               begin
                  rdata_d = {24'h00_0000, work_q};
               end
               else if (address_i == OFS_STATUS)
               begin
                  rdata_d[ST_CARRY] = carry_q;
                  rdata_d[ST_HALF] = half_q;
                  rdata_d[ST_ZERO] = zero_q;
                  rdata_d[ST_PD_N] = pd_n_q;
                  rdata_d[ST_TO_N] = to_n_q;
                  rdata_d[ST_HALTED] = (core_q == CORE_HALT);
               end
               else if (address_i == OFS_WDOG)
               begin
                  rdata_d = {16'h0000, wd_presc, wd_count};
               end
            end
         end
         default:
         begin
            bus_d = BUS_IDLE; // Answer lasts one cycle
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Core state, flags and working register
   // ---------------------------------------------------------------
   logic st_wr; // Status word write
   assign st_wr = wr_take && (address_i == OFS_STATUS) && byteenable_i[0];

   always_comb
   begin
      core_d = core_q;
      work_d = work_q;
      carry_d = carry_q;
      half_d = half_q;
      zero_d = zero_q;
      pd_n_d = pd_n_q;
      to_n_d = to_n_q;
      if (sleep_exec)
      begin
         to_n_d = 1'b1;
         pd_n_d = 1'b0;
         core_d = CORE_HALT;
      end
      else if (exec)
      begin
         if (alu_upd_c)
         begin
            carry_d = alu_c;
            half_d = alu_h;
         end
         if (alu_upd_z)
         begin
            zero_d = alu_z;
         end
         // Immediate forms always land in the working register
         if ((!reg_op || !dest) && (op != OP_NOP))
         begin
            work_d = alu_res;
         end
      end
      else if (wr_take && (address_i == OFS_WORK) && byteenable_i[0])
      begin
         work_d = writedata_i[7:0];
      end
      else if (st_wr)
      begin
         // Arithmetic flags are writable; the low-active pair is not
         carry_d = writedata_i[ST_CARRY];
         half_d = writedata_i[ST_HALF];
         zero_d = writedata_i[ST_ZERO];
      end
      // Resume stands in for the wake-up logic kept outside
      if (st_wr && writedata_i[ST_RESUME])
      begin
         core_d = CORE_RUN;
      end
   end

   // ---------------------------------------------------------------
   // Register file next values
   // ---------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < REG_NUM; i++)
      begin
         rf_d[i] = rf_q[i];
      end
      if (exec && reg_op && dest)
      begin
         rf_d[raddr] = alu_res;
      end
      else if (wr_take && rf_hit(address_i) && byteenable_i[0])
      begin
         rf_d[bus_idx] = writedata_i[7:0];
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (!rstn_i)
      begin
         bus_q <= BUS_IDLE;
         core_q <= CORE_RUN;
         rdata_q <= 32'h0000_0000;
         work_q <= WORK_RST;
         carry_q <= 1'b0;
         half_q <= 1'b0;
         zero_q <= 1'b0;
         pd_n_q <= PD_N_RST;
         to_n_q <= TO_N_RST;
         for (int i = 0; i < REG_NUM; i++)
         begin
            rf_q[i] <= 8'h00;
         end
      end
      else
      begin
         bus_q <= bus_d;
         core_q <= core_d;
         rdata_q <= rdata_d;
         work_q <= work_d;
         carry_q <= carry_d;
         half_q <= half_d;
         zero_q <= zero_d;
         pd_n_q <= pd_n_d;
         to_n_q <= to_n_d;
         rf_q <= rf_d;
      end
   end

   // Outputs
   assign readdata_o = rdata_q;
   assign waitrequest_o = req && (bus_q == BUS_IDLE);
   assign halted_o = (core_q == CORE_HALT);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Reference sum for the borrow form, seen by checks only
   logic [8:0] sbc_ref;
   assign sbc_ref = {1'b0, rval} + {1'b0, ~work_q} + {8'h00, carry_q};

   property p_sleep_wdog;
      @(posedge mclk_i) disable iff (!rstn_i)
      sleep_exec |=> (wd_count == 8'h00) && (wd_presc == 8'h00);
   endproperty
   a_sleep_wdog: assert property (p_sleep_wdog)
      else $error("watchdog not zero after sleep");
   property p_sleep_flags;
      @(posedge mclk_i) disable iff (!rstn_i)
      sleep_exec |=> to_n_q && !pd_n_q && $stable(carry_q) && $stable(half_q) && $stable(zero_q);
   endproperty
   a_sleep_flags: assert property (p_sleep_flags)
      else $error("sleep status flags wrong");
   property p_sleep_halt;
      @(posedge mclk_i) disable iff (!rstn_i)
      sleep_exec |=> halted_o ##1 (halted_o || $past(st_wr));
   endproperty
   a_sleep_halt: assert property (p_sleep_halt)
      else $error("core not halted after sleep");
   property p_sbc;
      @(posedge mclk_i) disable iff (!rstn_i)
      (exec && op == OP_SBC && !dest)
         |=> (work_q == $past(sbc_ref[7:0])) && (carry_q == $past(sbc_ref[8]));
   endproperty
   a_sbc: assert property (p_sbc)
      else $error("borrow subtract result wrong");
   property p_dest_reg;
      @(posedge mclk_i) disable iff (!rstn_i)
      (exec && reg_op && dest) |=> $stable(work_q);
   endproperty
   a_dest_reg: assert property (p_dest_reg)
      else $error("working register changed for file destination");
   property p_subr;
      @(posedge mclk_i) disable iff (!rstn_i)
      (exec && op == OP_SUBR && !dest) |=> (work_q == $past(rval - work_q))
         && (carry_q == ($past(rval) >= $past(work_q)))
         && (zero_q == (work_q == 8'h00));
   endproperty
   a_subr: assert property (p_subr)
      else $error("register minus work wrong");
   property p_subi;
      @(posedge mclk_i) disable iff (!rstn_i)
      (exec && op == OP_SUBI) |=> (work_q == $past(imm - work_q))
         && (half_q == ($past(imm[3:0]) >= $past(work_q[3:0])));
   endproperty
   a_subi: assert property (p_subi)
      else $error("immediate minus work wrong");
   property p_swap;
      @(posedge mclk_i) disable iff (!rstn_i)
      (exec && op == OP_SWAP)
         |=> $stable(carry_q) && $stable(half_q) && $stable(zero_q);
   endproperty
   a_swap: assert property (p_swap)
      else $error("nibble exchange touched a flag");
   property p_xor;
      @(posedge mclk_i) disable iff (!rstn_i)
      (exec && (op == OP_XORR || op == OP_XORI)) |=> $stable(carry_q) && $stable(half_q)
         && (zero_q == ($past(work_q ^ ((op == OP_XORI) ? imm : rval)) == 8'h00));
   endproperty
   a_xor: assert property (p_xor)
      else $error("xor flag update wrong");
endmodule // exec_unit
`default_nettype wire

// >>> core/exec_pkg.sv
// Constants and types shared by the execution datapath files.
// Assumes a 32-bit Avalon-MM register port, byte addressed.
package exec_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam int ADDR_W = 9; // Avalon byte address width
   localparam logic [8:0] OFS_INSTR = 9'h000; // Write issues one instruction
   localparam logic [8:0] OFS_WORK = 9'h004; // Working register
   localparam logic [8:0] OFS_STATUS = 9'h008; // Flags and halt state
   localparam logic [8:0] OFS_WDOG = 9'h00c; // Watchdog counter readback
   localparam logic [8:0] OFS_RF_BASE = 9'h100; // Register file window base
   // ---------------------------------------------------------------
   // Instruction word fields
   // ---------------------------------------------------------------
   localparam int INS_OP_LSB = 0; // Opcode bits 2:0
   localparam int INS_DEST_BIT = 3; // Destination select
   localparam int INS_REG_LSB = 8; // Register address bits 13:8
   localparam int INS_IMM_LSB = 16; // Immediate bits 23:16
   // ---------------------------------------------------------------
   // Status word fields
   // ---------------------------------------------------------------
   localparam int ST_CARRY = 0;
   localparam int ST_HALF = 1;
   localparam int ST_ZERO = 2;
   localparam int ST_PD_N = 3; // Power-down flag, active low
   localparam int ST_TO_N = 4; // Watchdog expiry flag, active low
   localparam int ST_HALTED = 5; // Core halted by sleep
   localparam int ST_RESUME = 8; // Write 1 to leave the halted state
   // ---------------------------------------------------------------
   // Sizes and reset values
   // ---------------------------------------------------------------
   localparam int REG_AW = 6; // Register addresses 0 to 0x3f
   localparam int REG_NUM = 64;
   localparam logic [7:0] WORK_RST = 8'h00;
   localparam logic PD_N_RST = 1'b1;
   localparam logic TO_N_RST = 1'b1;
   localparam logic [7:0] WDOG_CLR = 8'h00; // Value loaded by sleep
   localparam int WDOG_TICK_DIV = 16; // Clock cycles per prescaler step
   // ---------------------------------------------------------------
   // Opcodes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_NOP = 3'h0,
      OP_SLEEP = 3'h1,
      OP_SBC = 3'h2, // sub_with_borrow_reg
      OP_SUBR = 3'h3, // reg_minus_work
      OP_SUBI = 3'h4, // imm_minus_work
      OP_SWAP = 3'h5, // nibble_exchange
      OP_XORR = 3'h6, // exclusive_or_reg
      OP_XORI = 3'h7 // exclusive_or_imm
   } op_t;
endpackage

// >>> core/exec_alu.sv
// Combinational arithmetic unit for subtract, xor and nibble exchange.
// Assumes the caller registers results and gates flag updates.
`timescale 1ns/1ns
`default_nettype none
module exec_alu
   import exec_pkg::*;
(
   input wire op_t op_i, // Decoded opcode
   input wire logic [7:0] reg_i, // Addressed register value
   input wire logic [7:0] work_i, // Working register
   input wire logic [7:0] imm_i, // Immediate operand
   input wire logic carry_i, // Current carry flag
   output logic [7:0] res_o, // Result byte
   output logic carry_o, // New carry, 1 means no borrow
   output logic half_o, // New half carry, 1 means no nibble borrow
   output logic zero_o, // Result is zero
   output logic upd_c_o, // Carry and half carry change
   output logic upd_z_o // Zero flag changes
);
   // ---------------------------------------------------------------
   // Subtraction as a + ~work + cin
   // ---------------------------------------------------------------
   logic [7:0] sub_a; // Minuend
   logic sub_cin; // Carry into bit 0
   logic [8:0] sub_full; // Sum with carry out
   logic [4:0] sub_low; // Low nibble sum with carry out

   // Minuend and carry in by opcode
   always_comb
   begin
      sub_a = (op_i == OP_SUBI) ? imm_i : reg_i;
      // Borrow chain only for the with-borrow form
      sub_cin = (op_i == OP_SBC) ? carry_i : 1'b1;
      sub_full = {1'b0, sub_a} + {1'b0, ~work_i} + {8'h00, sub_cin};
      sub_low = {1'b0, sub_a[3:0]} + {1'b0, ~work_i[3:0]} + {4'h0, sub_cin};
   end

   // ---------------------------------------------------------------
   // Result select and flag enables
   // ---------------------------------------------------------------
   always_comb
   begin
      res_o = 8'h00;
      upd_c_o = 1'b0;
      upd_z_o = 1'b0;
      case (op_i)
         OP_SBC, OP_SUBR, OP_SUBI:
         begin
            res_o = sub_full[7:0];
            upd_c_o = 1'b1;
            upd_z_o = 1'b1;
         end
         OP_SWAP:
         begin
            res_o = {reg_i[3:0], reg_i[7:4]};
         end
         OP_XORR:
         begin
            res_o = work_i ^ reg_i;
            upd_z_o = 1'b1;
         end
         OP_XORI:
         begin
            res_o = work_i ^ imm_i;
            upd_z_o = 1'b1;
         end
         default:
         begin
            res_o = 8'h00; // Nop and sleep produce nothing
         end
      endcase
      carry_o = sub_full[8];
      half_o = sub_low[4];
      zero_o = (res_o == 8'h00);
   end
endmodule // exec_alu
`default_nettype wire

// >>> core/exec_wdog.sv
// Watchdog counter with prescaler, stepped by a clock-enable divider.
// Assumes one clock; expiry handling sits outside this block.
`timescale 1ns/1ns
`default_nettype none
module exec_wdog
   import exec_pkg::*;
#(
   parameter int TICK_DIV = WDOG_TICK_DIV // Clock cycles per step
)
(
   input wire logic mclk_i, // Core clock
   input wire logic rstn_i, // Synchronous reset, active low
   input wire logic clear_i, // Zero counter and prescaler
   output logic [7:0] count_o, // Counter value
   output logic [7:0] presc_o // Prescaler value
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [15:0] div_q, div_d; // Step divider
   logic [7:0] presc_q, presc_d; // Prescaler
   logic [7:0] count_q, count_d; // Counter
   logic tick; // One-cycle step enable

   // Next values; clear beats a coincident step
   always_comb
   begin
      tick = (div_q == 16'(TICK_DIV - 1));
      div_d = tick ? 16'h0000 : div_q + 16'h0001;
      presc_d = presc_q;
      count_d = count_q;
      if (clear_i)
      begin
         presc_d = WDOG_CLR;
         count_d = WDOG_CLR;
      end
      else if (tick)
      begin
         presc_d = presc_q + 8'h01;
         // Counter steps when the prescaler wraps
         if (presc_q == 8'hff)
         begin
            count_d = count_q + 8'h01;
         end
      end
   end

   // Registers only
   always_ff @(posedge mclk_i)
   begin
      if (!rstn_i)
      begin
         div_q <= 16'h0000;
         presc_q <= 8'h00;
         count_q <= 8'h00;
      end
      else
      begin
         div_q <= div_d;
         presc_q <= presc_d;
         count_q <= count_d;
      end
   end

   assign count_o = count_q;
   assign presc_o = presc_q;
endmodule // exec_wdog
`default_nettype wire

// >>> sim/alu_subtract_xor_swap_sleep_bench.sv
// Self-checking bench for exec_unit: instructions issued over Avalon-MM.
// Assumes exec_pkg offsets, one clock, and a reference model kept here.
`timescale 1ns/1ns
`default_nettype none
module alu_subtract_xor_swap_sleep_bench;
   import exec_pkg::*;
   logic mclk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0; // Clock, reset, strobes
   logic [8:0] addr = 9'h000; // Bus address
   logic [31:0] wdata = 32'h0, rdata, q; // Bus data
   logic wait_req, halted; // Design outputs
   logic [7:0] work_m, rf_m [64]; // Model state
   logic c_m, h_m, z_m, to_m, pd_m, hl_m; // Model flags
   int err_count = 0, check_count = 0;
   // Short divider so the watchdog counter moves within the run
   exec_unit #(.TICK_DIV(2)) exec_unit_i (.mclk_i(mclk), .rstn_i(rstn), .address_i(addr),
      .read_i(rd), .write_i(wr), .byteenable_i(4'hf), .writedata_i(wdata),
      .readdata_o(rdata), .waitrequest_o(wait_req), .halted_o(halted));
   initial forever #10 mclk = ~mclk;
   // ---------------------------------------------
   // Bus and compare tasks
   // ---------------------------------------------
   task end_sim;
      $display("Checks %0d, errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Holds the request until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (wait_req !== 1'b0 && n < 20);
      if (n >= 20)
         chk("waitrequest", 32'h0, 32'h1);
      // Read data taken at the same edge that sees waitrequest low
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic rdc(input string nm, input logic [8:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask
   function automatic logic [31:0] stat();
      return {26'h0, hl_m, to_m, pd_m, z_m, h_m, c_m};
   endfunction
   // Model one instruction, issue it, then compare work, flags and register
   task automatic exec(input op_t op, input logic dst, input logic [5:0] r,
      input logic [7:0] imm);
      logic [7:0] a, res;
      logic [8:0] s;
      logic [4:0] hs;
      logic ci;
      a = (op == OP_SUBI || op == OP_XORI) ? imm : rf_m[r];
      ci = (op == OP_SBC) ? c_m : 1'b1;
      s = {1'b0, a} + {1'b0, ~work_m} + 9'(ci);
      hs = {1'b0, a[3:0]} + {1'b0, ~work_m[3:0]} + 5'(ci);
      res = (op == OP_SWAP) ? {a[3:0], a[7:4]} : (op inside {OP_XORR, OP_XORI}) ?
         (a ^ work_m) : s[7:0];
      if (op inside {OP_SBC, OP_SUBR, OP_SUBI})
      begin
         c_m = s[8];
         h_m = hs[4];
      end
      if (op != OP_SWAP)
         z_m = (res == 8'h00);
      if (dst && (op inside {OP_SBC, OP_SUBR, OP_SWAP, OP_XORR}))
         rf_m[r] = res;
      else
         work_m = res;
      bus(1'b1, OFS_INSTR, {8'h00, imm, 2'b00, r, 4'h0, dst, op});
      rdc("work", OFS_WORK, {24'h0, work_m});
      rdc("status", OFS_STATUS, stat());
      rdc("regfile", OFS_RF_BASE + {1'b0, r, 2'b00}, {24'h0, rf_m[r]});
   endtask
   // ---------------------------------------------
   // Test sequence
   // ---------------------------------------------
   initial
   begin
      rf_m = '{default: 8'h00};
      {work_m, c_m, h_m, z_m, to_m, pd_m, hl_m} = {8'h00, 6'b000110};
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      rdc("status reset", OFS_STATUS, stat());
      rdc("unmapped", 9'h010, 32'h0);
      bus(1'b1, OFS_RF_BASE, 32'h3c);
      bus(1'b1, OFS_RF_BASE + 9'h0fc, 32'h80);
      bus(1'b1, OFS_RF_BASE + 9'h004, 32'h01);
      bus(1'b1, OFS_WORK, 32'h45);
      {rf_m[0], rf_m[63], rf_m[1], work_m} = 32'h3c800145;
      exec(OP_SUBR, 1'b0, 6'h00, 8'h00);
      exec(OP_SBC, 1'b1, 6'h3f, 8'h00);
      exec(OP_SBC, 1'b0, 6'h01, 8'h00);
      exec(OP_SUBI, 1'b0, 6'h00, 8'h09);
      exec(OP_SBC, 1'b0, 6'h3f, 8'h00);
      exec(OP_SWAP, 1'b1, 6'h00, 8'h00);
      exec(OP_SWAP, 1'b0, 6'h01, 8'h00);
      exec(OP_XORR, 1'b1, 6'h00, 8'h00);
      exec(OP_XORR, 1'b0, 6'h00, 8'h00);
      exec(OP_XORI, 1'b0, 6'h00, 8'hc3);
      exec(OP_XORI, 1'b0, 6'h00, 8'h01);
      exec(OP_SUBI, 1'b0, 6'h00, 8'h00);
      exec(OP_SUBR, 1'b1, 6'h01, 8'h00);
      // Nop must leave working register and flags alone
      bus(1'b1, OFS_INSTR, 32'h0000_0000);
      rdc("work nop", OFS_WORK, {24'h0, work_m});
      rdc("status nop", OFS_STATUS, stat());
      // Let the watchdog count so the sleep clear is visible
      repeat (1100) @(posedge mclk);
      bus(1'b0, OFS_WDOG, 32'h0);
      chk("wdog running", 32'h1, 32'(q[7:0] != 8'h00));
      bus(1'b1, OFS_INSTR, {29'h0, OP_SLEEP});
      {to_m, pd_m, hl_m} = 3'b101;
      @(posedge mclk);
      chk("halted", 32'h1, 32'(halted));
      bus(1'b0, OFS_WDOG, 32'h0);
      chk("wdog count", 32'h0, 32'(q[7:0]));
      chk("wdog prescaler", 32'h1, 32'(q[15:8] < 8'h04));
      rdc("status sleep", OFS_STATUS, stat());
      // Instructions while halted must not execute
      bus(1'b1, OFS_INSTR, {8'h00, 8'h55, 13'h0, OP_XORI});
      rdc("work halted", OFS_WORK, {24'h0, work_m});
      bus(1'b1, OFS_STATUS, 32'h105);
      {hl_m, z_m, h_m, c_m} = 4'b0101;
      rdc("status resume", OFS_STATUS, stat());
      end_sim;
   end
   // Cut a hang short; the run needs well under this
   initial
   begin
      #200000;
      err_count++;
      $display("Error timeout expected finish seen hang");
      end_sim;
   end
endmodule // alu_subtract_xor_swap_sleep_bench
`default_nettype wire
